// >>> core/spc_cfg.svh
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// geometry
`define SPC_NPORTS        4
`define SPC_PORT_SEL_W    4

// register indices; byte address is four times the index
`define SPC_IDX_DELAY     4'h3
`define SPC_IDX_SELFID    4'h4
`define SPC_IDX_EVENT     4'h5
`define SPC_IDX_PAGE      4'h7
`define SPC_IDX_WIN0      4'h8
`define SPC_IDX_WIN1      4'h9

// page numbers
`define SPC_PAGE_PORT     3'h0

// fixed read-only codes (delay = 144 + code*20 ns, skew = (code+1)*20 ns)
`define SPC_DELAY_BASE_NS 144
`define SPC_DELAY_STEP_NS 20
`define SPC_DELAY_CODE    4'h0
`define SPC_JITTER_CODE   3'h0

// reset values
`define SPC_LINK_ON_RST   1'b1
`define SPC_PAGE_RST      3'h0
`define SPC_PORT_RST      4'h0

// field positions inside the low byte (register bit 0 is data bit 7)
`define SPC_B_LINK_ON     7
`define SPC_B_CONTEND     6
`define SPC_B_RESUME_EN   7
`define SPC_B_SHORT_RST   6
`define SPC_B_LOOP        5
`define SPC_B_PWR_FAIL    4
`define SPC_B_TIMEOUT     3
`define SPC_B_PORT_EVT    2
`define SPC_B_FAST_ARB    1
`define SPC_B_MULTI_SPD   0
`define SPC_B_PORT_DIS    0
`define SPC_B_PORT_IRQ    4
`define SPC_B_PORT_FAULT  3

`endif

// >>> core/spc_pkg.sv
package spc_pkg;

  // live status of one cable port
  typedef struct packed {
    logic [1:0] line_a;
    logic [1:0] line_b;
    logic       child;
    logic       connected;
    logic       bias;
    logic [2:0] agreed_rate;
  } spc_port_stat_t;

  // fields sent in the self-identify packet
  typedef struct packed {
    logic       l_bit;
    logic       c_bit;
    logic [2:0] pwr;
  } spc_selfid_t;

  typedef enum logic [1:0] {
    SPC_HTRANS_IDLE   = 2'b00,
    SPC_HTRANS_BUSY   = 2'b01,
    SPC_HTRANS_NONSEQ = 2'b10,
    SPC_HTRANS_SEQ    = 2'b11
  } spc_htrans_t;

endpackage

// >>> core/spc_port_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"

module spc_port_regs (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // live port status
  input  wire spc_pkg::spc_port_stat_t stat,
  input  wire logic                   fault_evt,
  // register writes to the window
  input  wire logic                   wr_win0,
  input  wire logic                   wr_win1,
  input  wire logic [7:0]             wdata,
  // results
  output logic                        disabled,
  output logic                        changed,
  output logic [7:0]                  rd_win0,
  output logic [7:0]                  rd_win1
);
  import spc_pkg::*;

  logic       disabled_r;
  logic       int_en_r;
  logic       fault_r;
  logic [3:0] prev_r;
  logic [3:0] now_state;

  // software port disable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      disabled_r <= 1'b0;
    end else if (wr_win0) begin
      disabled_r <= wdata[`SPC_B_PORT_DIS];
    end
  end

  // port interrupt enable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_en_r <= 1'b0;
    end else if (wr_win1) begin
      int_en_r <= wdata[`SPC_B_PORT_IRQ];
    end
  end

  // fault flag, set beats a write-one clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_r <= 1'b0;
    end else if (fault_evt) begin
      fault_r <= 1'b1;
    end else if (wr_win1 && wdata[`SPC_B_PORT_FAULT]) begin
      fault_r <= 1'b0;
    end
  end

  // change detect on connected, bias, disabled, fault
  assign now_state = {stat.connected, stat.bias, disabled_r, fault_r};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_r <= 4'h0;
    end else begin
      prev_r <= now_state;
    end
  end

  assign changed  = int_en_r && (now_state != prev_r);
  assign disabled = disabled_r;

  // window bytes, register bit 0 is the top data bit
  assign rd_win0 = {stat.line_a, stat.line_b, stat.child,
                    stat.connected, stat.bias, disabled_r};
  assign rd_win1 = {stat.agreed_rate, int_en_r, fault_r, 3'h0};

endmodule

`default_nettype wire

// >>> core/spc_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"

module spc_regs (
  // clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              rst,
  // ahb-lite slave
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output logic [31:0]                            hrdata,
  output logic                                   hreadyout,
  output logic                                   hresp,
  // straps and link status
  input  wire logic                              link_power_status,
  input  wire logic                              contend_strap_pin,
  input  wire logic [2:0]                        power_category_straps,
  input  wire logic                              cable_power_present,
  // events from the arbitration logic
  input  wire logic                              loop_detect_evt,
  input  wire logic                              arb_timeout_evt,
  input  wire logic                              short_reset_done,
  input  wire logic [`SPC_NPORTS-1:0]            resume_start,
  // cable port status
  input  wire spc_pkg::spc_port_stat_t [`SPC_NPORTS-1:0] port_stat,
  input  wire logic [`SPC_NPORTS-1:0]            port_fault_evt,
  // controls to the physical layer
  output spc_pkg::spc_selfid_t                   self_id,
  output logic                                   arb_short_reset_req,
  output logic                                   fast_arb_en,
  output logic                                   multi_speed_en,
  output logic [`SPC_NPORTS-1:0]                 port_disable
);
  import spc_pkg::*;

  // bus phase state
  logic        wr_pend_r;
  logic [3:0]  wr_idx_r;
  logic        addr_ok;
  logic        take;
  logic [3:0]  a_idx;
  logic [7:0]  wd;
  logic        wr_selfid;
  logic        wr_event;
  logic        wr_page;
  logic        wr_win0;
  logic        wr_win1;

  // control and flag state
  logic        link_on_r;
  logic        contend_r;
  logic [2:0]  pwr_cat_r;
  logic        resume_en_r;
  logic        short_rst_r;
  logic        loop_r;
  logic        pwr_fail_r;
  logic        timeout_r;
  logic        port_evt_r;
  logic        fast_arb_r;
  logic        multi_spd_r;
  logic [2:0]  page_r;
  logic [3:0]  port_sel_r;
  logic        power_prev_r;

  // per-port results
  logic [`SPC_NPORTS-1:0] p_changed;
  logic [`SPC_NPORTS-1:0] p_disabled;
  logic [7:0]  p_rd0 [`SPC_NPORTS];
  logic [7:0]  p_rd1 [`SPC_NPORTS];
  logic        port_window;
  logic        port_evt_set;
  logic [7:0]  rd_byte;

  // output flops
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  logic        hresp_r;
  spc_selfid_t self_id_r;
  logic        short_req_r;
  logic [`SPC_NPORTS-1:0] port_dis_r;

  // address phase decode
  assign a_idx   = haddr[5:2];
  assign addr_ok = (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'b00);
  assign take    = hsel && hready &&
                   (htrans == SPC_HTRANS_NONSEQ || htrans == SPC_HTRANS_SEQ);

  // latch a write into its data phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 4'h0;
    end else if (hready) begin
      wr_pend_r <= take && hwrite && addr_ok;
      wr_idx_r  <= a_idx;
    end
  end

  // data phase write strobes
  assign wd        = hwdata[7:0];
  assign wr_selfid = wr_pend_r && (wr_idx_r == `SPC_IDX_SELFID);
  assign wr_event  = wr_pend_r && (wr_idx_r == `SPC_IDX_EVENT);
  assign wr_page   = wr_pend_r && (wr_idx_r == `SPC_IDX_PAGE);
  assign wr_win0   = wr_pend_r && (wr_idx_r == `SPC_IDX_WIN0);
  assign wr_win1   = wr_pend_r && (wr_idx_r == `SPC_IDX_WIN1);

  // link-on control
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link_on_r <= `SPC_LINK_ON_RST;
    end else if (wr_selfid) begin
      link_on_r <= wd[`SPC_B_LINK_ON];
    end
  end

  // contender and power category, loaded from straps under reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      contend_r <= contend_strap_pin;
      pwr_cat_r <= power_category_straps;
    end else if (wr_selfid) begin
      contend_r <= wd[`SPC_B_CONTEND];
      pwr_cat_r <= wd[2:0];
    end
  end

  // self-identify fields toward the packet builder
  always_ff @(posedge core_clk) begin
    if (rst) begin
      self_id_r <= '0;
    end else begin
      self_id_r.l_bit <= link_on_r && link_power_status;
      self_id_r.c_bit <= contend_r;
      self_id_r.pwr   <= pwr_cat_r;
    end
  end

  // plain enables in the event register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      resume_en_r <= 1'b0;
      fast_arb_r  <= 1'b0;
      multi_spd_r <= 1'b0;
    end else if (wr_event) begin
      resume_en_r <= wd[`SPC_B_RESUME_EN];
      fast_arb_r  <= wd[`SPC_B_FAST_ARB];
      multi_spd_r <= wd[`SPC_B_MULTI_SPD];
    end
  end

  // short bus reset request, held until the arbiter reports done
  always_ff @(posedge core_clk) begin
    if (rst) begin
      short_rst_r <= 1'b0;
    end else if (wr_event && wd[`SPC_B_SHORT_RST]) begin
      short_rst_r <= 1'b1;
    end else if (short_reset_done) begin
      short_rst_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      short_req_r <= 1'b0;
    end else begin
      short_req_r <= short_rst_r;
    end
  end

  // loop flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      loop_r <= 1'b0;
    end else if (loop_detect_evt) begin
      loop_r <= 1'b1;
    end else if (wr_event && wd[`SPC_B_LOOP]) begin
      loop_r <= 1'b0;
    end
  end

  // cable power falling edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      power_prev_r <= 1'b0;
    end else begin
      power_prev_r <= cable_power_present;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwr_fail_r <= 1'b0;
    end else if (power_prev_r && !cable_power_present) begin
      pwr_fail_r <= 1'b1;
    end else if (wr_event && wd[`SPC_B_PWR_FAIL]) begin
      pwr_fail_r <= 1'b0;
    end
  end

  // arbitration timeout flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timeout_r <= 1'b0;
    end else if (arb_timeout_evt) begin
      timeout_r <= 1'b1;
    end else if (wr_event && wd[`SPC_B_TIMEOUT]) begin
      timeout_r <= 1'b0;
    end
  end

  // port event flag from status changes and resume starts
  assign port_evt_set = (|p_changed) ||
                        (resume_en_r && (|resume_start));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      port_evt_r <= 1'b0;
    end else if (port_evt_set) begin
      port_evt_r <= 1'b1;
    end else if (wr_event && wd[`SPC_B_PORT_EVT]) begin
      port_evt_r <= 1'b0;
    end
  end

  // page and port choice
  always_ff @(posedge core_clk) begin
    if (rst) begin
      page_r     <= `SPC_PAGE_RST;
      port_sel_r <= `SPC_PORT_RST;
    end else if (wr_page) begin
      page_r     <= wd[7:5];
      port_sel_r <= wd[3:0];
    end
  end

  // one register slice per cable port
  for (genvar i = 0; i < `SPC_NPORTS; i++) begin : g_port
    spc_port_regs u_port (
      .core_clk  (core_clk),
      .rst       (rst),
      .stat      (port_stat[i]),
      .fault_evt (port_fault_evt[i]),
      .wr_win0   (wr_win0 && port_window &&
                  (port_sel_r == 4'(i))),
      .wr_win1   (wr_win1 && port_window &&
                  (port_sel_r == 4'(i))),
      .wdata     (wd),
      .disabled  (p_disabled[i]),
      .changed   (p_changed[i]),
      .rd_win0   (p_rd0[i]),
      .rd_win1   (p_rd1[i])
    );
  end

  // window maps to a port only on the port page with a real port
  assign port_window = (page_r == `SPC_PAGE_PORT) &&
                       (port_sel_r < 4'(`SPC_NPORTS));

  // read mux on the address phase
  always_comb begin
    rd_byte = 8'h00;
    unique case (a_idx)
      `SPC_IDX_DELAY:  rd_byte = {4'h0, `SPC_DELAY_CODE};
      `SPC_IDX_SELFID: rd_byte = {link_on_r, contend_r,
                                  `SPC_JITTER_CODE, pwr_cat_r};
      `SPC_IDX_EVENT:  rd_byte = {resume_en_r, short_rst_r, loop_r,
                                  pwr_fail_r, timeout_r, port_evt_r,
                                  fast_arb_r, multi_spd_r};
      `SPC_IDX_PAGE:   rd_byte = {page_r, 1'b0, port_sel_r};
      `SPC_IDX_WIN0: begin
        if (port_window) begin
          rd_byte = p_rd0[port_sel_r[1:0]];
        end
      end
      `SPC_IDX_WIN1: begin
        if (port_window) begin
          rd_byte = p_rd1[port_sel_r[1:0]];
        end
      end
      default:         rd_byte = 8'h00;
    endcase
  end

  // read data register, zero-wait answer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrdata_r <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata_r <= addr_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // slave is always ready, always okay
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  // port disable outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      port_dis_r <= '0;
    end else begin
      port_dis_r <= p_disabled;
    end
  end

  assign hrdata              = hrdata_r;
  assign hreadyout           = hreadyout_r;
  assign hresp               = hresp_r;
  assign self_id             = self_id_r;
  assign arb_short_reset_req = short_req_r;
  assign fast_arb_en         = fast_arb_r;
  assign multi_speed_en      = multi_spd_r;
  assign port_disable        = port_dis_r;

endmodule

`default_nettype wire

// >>> verification/spc_arb_model.sv
`timescale 1ns/1ps
`default_nettype none

module spc_arb_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // request and pace
  input  wire logic arb_short_reset_req,
  input  wire logic slow,
  // completion
  output logic      short_reset_done
);
  logic [3:0] cnt_r;
  logic       busy_r;

  // win arbitration, run the short reset, pulse done once per request
  always_ff @(posedge core_clk) begin
    short_reset_done <= 1'b0;
    if (rst || !arb_short_reset_req) begin
      cnt_r  <= 4'h0;
      busy_r <= 1'b0;
    end else if (!busy_r) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == (slow ? 4'hb : 4'h1)) begin
        short_reset_done <= 1'b1;
        busy_r           <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// >>> verification/spc_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"

module spc_regs_props (
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst,
  // bus
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [31:0]            hwdata,
  input wire logic                   hready,
  input wire logic [31:0]            hrdata,
  // status and controls
  input wire logic                   link_power_status,
  input wire logic                   short_reset_done,
  input wire spc_pkg::spc_selfid_t   self_id,
  input wire logic                   arb_short_reset_req,
  input wire logic                   fast_arb_en,
  input wire logic                   multi_speed_en,
  input wire logic [`SPC_NPORTS-1:0] port_disable
);
  import spc_pkg::*;
  logic        ap_v_r;
  logic        ap_w_r;
  logic [31:0] ap_a_r;
  logic        rd_dp;
  logic        wr_dp;

  // track the address phase into its data phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ap_v_r <= 1'b0;
    end else begin
      ap_v_r <= hsel && hready && htrans[1];
    end
    ap_w_r <= hwrite;
    ap_a_r <= haddr;
  end
  assign rd_dp = ap_v_r && !ap_w_r;
  assign wr_dp = ap_v_r && ap_w_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_delay_zero: assert property (rd_dp && ap_a_r == 32'h0c |-> hrdata == 32'h0)
    else $error("delay code read not zero");
  chk_skew_zero: assert property (rd_dp && ap_a_r == 32'h10 |-> hrdata[31:3] == 29'h0 ||
    hrdata[31:8] == 24'h0 && hrdata[5:3] == 3'h0) else $error("skew code read not zero");
  chk_unmapped_zero: assert property (rd_dp && !(ap_a_r inside {32'h0c, 32'h10, 32'h14,
    32'h1c, 32'h20, 32'h24}) |-> hrdata == 32'h0) else $error("unmapped read not zero");
  chk_choice_resv: assert property (rd_dp && ap_a_r == 32'h1c |->
    hrdata[31:8] == 24'h0 && !hrdata[4]) else $error("choice register reserved bits set");
  chk_lbit_gate: assert property (!$past(link_power_status) |-> !self_id.l_bit)
    else $error("l bit high without power status");
  chk_short_rise: assert property (wr_dp && ap_a_r == 32'h14 && hwdata[6]
    |-> ##[1:3] arb_short_reset_req) else $error("short reset not requested");
  chk_short_clear: assert property (short_reset_done |-> ##[1:2] !arb_short_reset_req)
    else $error("short reset request did not clear");
  chk_ctrl_bits: assert property (wr_dp && ap_a_r == 32'h14 |=>
    fast_arb_en == $past(hwdata[1]) && multi_speed_en == $past(hwdata[0]))
    else $error("control bits not written");
  chk_reset_vals: assert property ($fell(rst) |-> !fast_arb_en && !multi_speed_en &&
    port_disable == '0 && !arb_short_reset_req) else $error("controls not reset");

  cover property ($rose(arb_short_reset_req));
  cover property ($rose(fast_arb_en));
  cover property (port_disable != '0);
endmodule

bind spc_regs spc_regs_props u_props (
  .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .link_power_status(link_power_status), .short_reset_done(short_reset_done),
  .self_id(self_id), .arb_short_reset_req(arb_short_reset_req), .fast_arb_en(fast_arb_en),
  .multi_speed_en(multi_speed_en), .port_disable(port_disable)
);

`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import spc_pkg::*;
  logic                      core_clk, rst, hsel, hwrite, hready, hreadyout, hresp, slow;
  logic [31:0]               haddr, hwdata, hrdata, r, seed;
  logic [1:0]                htrans;
  logic [2:0]                hsize, power_category_straps;
  logic                      link_power_status, contend_strap_pin, cable_power_present;
  logic                      loop_detect_evt, arb_timeout_evt, short_reset_done;
  logic                      arb_short_reset_req, fast_arb_en, multi_speed_en;
  logic [3:0]                resume_start, port_fault_evt, port_disable, dis, ie, flt;
  spc_port_stat_t [3:0]      port_stat;
  spc_selfid_t               self_id;
  logic [7:0]                ev, sid;
  int                        fail_count, check_count, pg, pt, i, p;
  localparam logic [31:0]    AM [9] = '{32'h0c, 32'h10, 32'h14, 32'h1c, 32'h20, 32'h24,
                                        32'h18, 32'h11, 32'h50};

  always #25 core_clk = ~core_clk;
  assign hready = hreadyout;

  spc_regs DUT (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_power_status(link_power_status),
    .contend_strap_pin(contend_strap_pin), .power_category_straps(power_category_straps),
    .cable_power_present(cable_power_present), .loop_detect_evt(loop_detect_evt),
    .arb_timeout_evt(arb_timeout_evt), .short_reset_done(short_reset_done),
    .resume_start(resume_start), .port_stat(port_stat), .port_fault_evt(port_fault_evt),
    .self_id(self_id), .arb_short_reset_req(arb_short_reset_req), .fast_arb_en(fast_arb_en),
    .multi_speed_en(multi_speed_en), .port_disable(port_disable));

  spc_arb_model u_arb (.core_clk(core_clk), .rst(rst), .arb_short_reset_req(arb_short_reset_req),
    .slow(slow), .short_reset_done(short_reset_done));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected read value from the model state
  function automatic logic [7:0] exp_rd(input logic [31:0] a);
    spc_port_stat_t s;
    logic           ok;
    s = port_stat[pt[1:0]];
    ok = pg == 0 && pt < 4;
    case (a)
      32'h10: return sid;
      32'h14: return ev;
      32'h1c: return {pg[2:0], 1'b0, pt[3:0]};
      32'h20: return ok ? {s.line_a, s.line_b, s.child, s.connected, s.bias, dis[pt]} : 8'h0;
      32'h24: return ok ? {s.agreed_rate, ie[pt], flt[pt], 3'h0} : 8'h0;
      default: return 8'h0;
    endcase
  endfunction

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // one bus transfer; write data or read compare
  task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
    logic [7:0] e;
    e = exp_rd(a);
    haddr  <= a;
    hwrite <= w;
    htrans <= SPC_HTRANS_NONSEQ;
    hsel   <= 1'b1;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= SPC_HTRANS_IDLE;
    hwdata <= {24'h0, d};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    if (!w) check(hrdata, {24'h0, e});
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
    case (a)
      32'h10: sid = {d[7:6], 3'h0, d[2:0]};
      32'h14: ev = (d & 8'h83) | (ev & ~d & 8'h3c) | ((d | ev) & 8'h40);
      32'h1c: begin
        pg = d[7:5];
        pt = d[3:0];
      end
      32'h20: if (pg == 0 && pt < 4) begin
        if (ie[pt] && dis[pt] != d[0]) ev |= 8'h04;
        dis[pt] = d[0];
      end
      32'h24: if (pg == 0 && pt < 4) ie[pt] = d[4];
      default: ;
    endcase
  endtask

  task automatic rc(input logic [31:0] a);
    xfer(a, 1'b0, 8'h0);
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    tick(4000);
    fail_count++;
    report_and_stop();
  end

  // main sequence
  initial begin
    seed = 32'd87038;
    core_clk = 0; rst = 1; hsel = 0; haddr = 0; hwrite = 0; hwdata = 0; hsize = 3'h2;
    htrans = SPC_HTRANS_IDLE; slow = 1; loop_detect_evt = 0; arb_timeout_evt = 0;
    resume_start = 0; port_fault_evt = 0; cable_power_present = 1; link_power_status = 1;
    r = rnd();
    contend_strap_pin = r[0];
    power_category_straps = r[3:1];
    for (i = 0; i < 4; i++) port_stat[i] = 10'(rnd());
    ev = 0; pg = 0; pt = 0; dis = 0; ie = 0; flt = 0;
    sid = {1'b1, r[0], 3'h0, r[3:1]};
    tick(5);
    rst <= 1'b0;
    tick(1);
    for (i = 0; i < 9; i++) rc(AM[i]);
    check({27'h0, self_id}, {27'h0, 1'b1, r[0], r[3:1]});
    wr(32'h0c, 8'hff);
    rc(32'h0c);
    for (i = 0; i < 8; i++) begin
      r = rnd();
      link_power_status <= r[4];
      wr(32'h10, {r[7:6], 3'h7, i[2:0]});
      rc(32'h10);
      check({27'h0, self_id}, {27'h0, r[7] & r[4], r[6], i[2:0]});
    end
    // raise loop, timeout and power loss flags
    loop_detect_evt <= 1; arb_timeout_evt <= 1; cable_power_present <= 0;
    tick(1);
    loop_detect_evt <= 0; arb_timeout_evt <= 0;
    tick(1);
    ev |= 8'h38;
    rc(32'h14);
    loop_detect_evt <= 1;
    wr(32'h14, (ev & 8'h83) | 8'h38);
    loop_detect_evt <= 0;
    ev |= 8'h20;
    rc(32'h14);
    wr(32'h14, (ev & 8'h83) | 8'h20);
    rc(32'h14);
    // short reset, slow then prompt arbitration
    for (i = 0; i < 2; i++) begin
      slow <= (i == 0);
      wr(32'h14, {6'h10, i[0], !i[0]});
      if (i == 0) rc(32'h14);
      #1 check({30'h0, fast_arb_en, multi_speed_en}, {30'h0, ev[1:0]});
      tick(3);
      for (p = 0; p < 40 && arb_short_reset_req !== 1'b0; p++) tick(1);
      ev[6] = 0;
      rc(32'h14);
    end
    // each port: status page, disable, fault, port event
    for (p = 0; p < 4; p++) begin
      wr(32'h1c, 8'(p));
      rc(32'h20);
      wr(32'h24, 8'h10);
      wr(32'h20, 8'h01);
      tick(1);
      port_fault_evt[p] <= 1'b1;
      #1 check({28'h0, port_disable}, {28'h0, dis});
      tick(1);
      port_fault_evt <= 0;
      flt[p] = 1;
      rc(32'h20);
      rc(32'h24);
      rc(32'h14);
      wr(32'h14, (ev & 8'h83) | 8'h04);
      rc(32'h14);
    end
    wr(32'h1c, 8'h05);
    rc(32'h20);
    wr(32'h1c, 8'h20);
    wr(32'h20, 8'h00);
    rc(32'h24);
    // resume start with enable off, then on
    for (i = 0; i < 2; i++) begin
      wr(32'h14, {i[0], 7'h0} | (ev & 8'h03));
      resume_start <= 4'h4;
      tick(1);
      resume_start <= 4'h0;
      tick(1);
      if (i == 1) ev |= 8'h04;
      rc(32'h14);
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
